// ==== rtl/hrub_bridge.v ====
// hrub_bridge.v: report decoder, tx/rx fifos and serial engine of the hid report uart bridge
// assumes a usb engine on sys_clk that strobes report bytes in and pulls rx bytes out
// Operation
// - data report id 0x01..0x3f equals payload byte count
// - every out-report payload byte (1..63) is queued for transmit unless the tx fifo is full
// - received bytes return in in-reports of 1..63 bytes, also on demand
// - config report 0x50 carries 4-byte baud at offset 1, read and write
// - baud 300..500000 accepted; bit timing made at that rate
// - parity byte selects none, even, odd, mark, space; bit appended
// - parity none means no parity bit in sent or expected frames
// - flow byte selects none or rts/cts hardware handshaking
// - data bits byte 5..8 selects character length
// - five data bits: long stop is one and a half bit times
// - six to eight data bits: long stop is two bit times
// - configuration is volatile and returns to defaults on reset
// - break report 0x51 holds tx low for 0..125 ms
// - starting a break discards the transmit fifo
// - break duration zero lasts until the stop-break report
// - stop-break report 0x52 ends a break, ignored when idle
// - flush policy bits: tx open, tx close, rx open, rx close
// - any combination of flush bits accepted, each applied alone
// - flush policy programming takes effect only the first time
// - enable is open, disable is close; purge per stored policy
// - fifos hold 480 bytes each; occupancy reported as 16-bit counts
// - break-in-progress status flag is exposed
`timescale 1ns/10ps
`include "hrub_map.vh"
module hrub_bridge #(
   parameter DEPTH  = `HRUB_FIFO_DEPTH,
   parameter MS_CYC = `HRUB_MS_CYC
) (
   // clock and reset
   input  wire        sys_clk,
   input  wire        sys_rst,
   // report bytes, rpt_first marks the id
   input  wire        rpt_valid,
   input  wire        rpt_first,
   input  wire [7:0]  rpt_byte,
   // in-report pull side
   input  wire        rx_pop,
   output wire        rx_avail,
   output reg  [7:0]  rx_data_ff,
   output wire [7:0]  in_report_id,
   // flush policy and port enable
   input  wire        policy_wr,
   input  wire [7:0]  policy_val,
   input  wire        uart_enable,
   // status
   output wire [15:0] tx_count,
   output wire [15:0] rx_count,
   output wire        break_active,
   output reg  [31:0] cfg_baud_ff,
   output reg  [2:0]  cfg_parity_ff,
   output reg         cfg_flow_ff,
   output reg  [3:0]  cfg_bits_ff,
   output reg         cfg_stop_ff,
   output wire        parity_err,
   // serial pins
   output reg         uart_tx_ff,
   input  wire        uart_rx,
   output wire        uart_rts_n,
   input  wire        uart_cts_n
);
   localparam AW = 9;
   localparam [AW-1:0] LAST = DEPTH - 1;
   // report decoder states
   localparam [1:0] RD_IDLE = 2'h0, RD_DATA = 2'h1, RD_CFG = 2'h2, RD_BRK = 2'h3;
   // serial tx states
   localparam [2:0] TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4;

   function [AW-1:0] hrub_inc;
      input [AW-1:0] p;
      hrub_inc = (p == LAST) ? {AW{1'b0}} : p + 1'b1;
   endfunction

   function hrub_par;
      input [2:0] mode;
      input [7:0] d;
      input [3:0] n;
      reg x;
      begin
         x = ^(d & ((8'h01 << n) - 8'h01));
         case (mode)
            `HRUB_PAR_EVEN:  hrub_par = x;
            `HRUB_PAR_ODD:   hrub_par = ~x;
            `HRUB_PAR_MARK:  hrub_par = 1'b1;
            default:         hrub_par = 1'b0;
         endcase
      end
   endfunction

   // fifos
   reg [7:0]    tx_mem [0:DEPTH-1];
   reg [7:0]    rx_mem [0:DEPTH-1];
   reg [AW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
   reg [15:0]   tx_cnt_ff, rx_cnt_ff;
   reg [1:0]    rd_st_ff;
   reg [5:0]    rd_left_ff;
   reg [2:0]    rd_idx_ff;
   reg [31:0]   baud_sh_ff;
   reg [2:0]    par_sh_ff;
   reg          flow_sh_ff, stop_sh_ff;
   reg [3:0]    bits_sh_ff;
   reg [3:0]    policy_ff;
   reg          policy_done_ff;
   reg          en_ff;
   reg          brk_ff, brk_inf_ff;
   reg [7:0]    brk_ms_ff;
   reg [15:0]   ms_cnt_ff;
   reg [2:0]    tx_st_ff;
   reg [7:0]    tx_sh_ff;
   reg [3:0]    tx_n_ff;
   reg          tx_p_ff;
   reg [31:0]   tx_acc_ff;
   reg [2:0]    tx_half_ff;
   reg [31:0]   rx_acc_ff;
   reg [2:0]    rx_st_ff;
   reg [3:0]    rx_n_ff, rx_bit_ff;
   reg [7:0]    rx_sh_ff;
   reg          rx_s1_ff, rx_s2_ff, cts_s1_ff, cts_s2_ff;
   reg          perr_ff, rx_pbit_ff;

   // 16x rx tick
   wire [31:0] baud16 = {cfg_baud_ff[27:0], 4'h0};
   wire        tick16 = (rx_acc_ff + baud16) >= `HRUB_CLK_HZ;
   // half-bit tx tick for 1.5 stops
   wire [31:0] baud2  = {cfg_baud_ff[30:0], 1'b0};
   wire        tick2  = (tx_acc_ff + baud2) >= `HRUB_CLK_HZ;

   wire byte_data = rpt_valid && !rpt_first && rd_st_ff == RD_DATA;
   wire tx_full   = tx_cnt_ff == DEPTH;
   wire rx_full   = rx_cnt_ff == DEPTH;
   wire open_ev   = uart_enable && !en_ff;
   wire close_ev  = !uart_enable && en_ff;
   wire brk_start = rpt_valid && !rpt_first && rd_st_ff == RD_BRK && rpt_byte <= `HRUB_BRK_MAX_MS;
   wire flush_tx  = (open_ev && policy_ff[`HRUB_FLUSH_TX_OPEN]) ||
                    (close_ev && policy_ff[`HRUB_FLUSH_TX_CLOSE]) || brk_start;
   wire flush_rx  = (open_ev && policy_ff[`HRUB_FLUSH_RX_OPEN]) ||
                    (close_ev && policy_ff[`HRUB_FLUSH_RX_CLOSE]);
   wire tx_take   = tx_st_ff == TX_IDLE && tx_cnt_ff != 16'h0 && !brk_ff && tick2 &&
                    (!cfg_flow_ff || !cts_s2_ff);
   wire rx_done   = rx_st_ff == 3'h4 && tick16 && rx_n_ff == 4'hf;

   assign tx_count     = tx_cnt_ff;
   assign rx_count     = rx_cnt_ff;
   assign rx_avail     = rx_cnt_ff != 16'h0;
   assign in_report_id = (rx_cnt_ff > 16'd63) ? `HRUB_ID_DATA_MAX : rx_cnt_ff[7:0];
   assign break_active = brk_ff;
   assign parity_err   = perr_ff;
   assign uart_rts_n   = cfg_flow_ff ? (rx_cnt_ff >= DEPTH - 16) : 1'b0;

   // report decoder
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_st_ff <= RD_IDLE;
         rd_left_ff <= 6'h0;
         rd_idx_ff <= 3'h0;
         baud_sh_ff <= 32'h0;
         par_sh_ff <= 3'h0;
         flow_sh_ff <= 1'b0;
         bits_sh_ff <= 4'h0;
         stop_sh_ff <= 1'b0;
         cfg_baud_ff <= `HRUB_BAUD_DEF;
         cfg_parity_ff <= `HRUB_PAR_NONE;
         cfg_flow_ff <= 1'b0;
         cfg_bits_ff <= `HRUB_BITS_DEF;
         cfg_stop_ff <= 1'b0;
         policy_ff <= 4'h0;
         policy_done_ff <= 1'b0;
         en_ff <= 1'b0;
      end else begin
         en_ff <= uart_enable;
         if (policy_wr && !policy_done_ff) begin
            policy_ff <= policy_val[3:0];
            policy_done_ff <= 1'b1;
         end
         if (rpt_valid && rpt_first) begin
            rd_idx_ff <= 3'h0;
            if (rpt_byte >= `HRUB_ID_DATA_MIN && rpt_byte <= `HRUB_ID_DATA_MAX) begin
               rd_st_ff <= RD_DATA;
               rd_left_ff <= rpt_byte[5:0];
            end else if (rpt_byte == `HRUB_ID_CONFIG)
               rd_st_ff <= RD_CFG;
            else if (rpt_byte == `HRUB_ID_BRK_SET)
               rd_st_ff <= RD_BRK;
            else
               rd_st_ff <= RD_IDLE;
         end else if (rpt_valid) begin
            case (rd_st_ff)
               RD_DATA: begin
                  rd_left_ff <= rd_left_ff - 6'h1;
                  if (rd_left_ff == 6'h1)
                     rd_st_ff <= RD_IDLE;
               end
               RD_CFG: begin
                  rd_idx_ff <= rd_idx_ff + 3'h1;
                  case (rd_idx_ff)
                     3'h0, 3'h1, 3'h2, 3'h3: baud_sh_ff <= {rpt_byte, baud_sh_ff[31:8]};
                     3'h4: par_sh_ff <= rpt_byte[2:0];
                     3'h5: flow_sh_ff <= rpt_byte[0];
                     3'h6: bits_sh_ff <= rpt_byte[3:0];
                     default: begin
                        stop_sh_ff <= rpt_byte[0];
                        rd_st_ff <= RD_IDLE;
                        if (baud_sh_ff >= `HRUB_BAUD_MIN && baud_sh_ff <= `HRUB_BAUD_MAX &&
                            par_sh_ff <= `HRUB_PAR_SPACE && bits_sh_ff >= 4'h5 &&
                            bits_sh_ff <= 4'h8 && rpt_byte[7:1] == 7'h0) begin
                           cfg_baud_ff <= baud_sh_ff;
                           cfg_parity_ff <= par_sh_ff;
                           cfg_flow_ff <= flow_sh_ff;
                           cfg_bits_ff <= bits_sh_ff;
                           cfg_stop_ff <= rpt_byte[0];
                        end
                     end
                  endcase
               end
               default: rd_st_ff <= RD_IDLE;
            endcase
         end
      end
   end

   // break timing
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         brk_ff <= 1'b0;
         brk_inf_ff <= 1'b0;
         brk_ms_ff <= 8'h0;
         ms_cnt_ff <= 16'h0;
      end else if (brk_start) begin
         brk_ff <= 1'b1;
         brk_inf_ff <= rpt_byte == 8'h0;
         brk_ms_ff <= rpt_byte;
         ms_cnt_ff <= 16'h0;
      end else if (rpt_valid && rpt_first && rpt_byte == `HRUB_ID_BRK_STOP) begin
         brk_ff <= 1'b0;
      end else if (brk_ff && !brk_inf_ff) begin
         if (ms_cnt_ff == MS_CYC[15:0] - 16'h1) begin
            ms_cnt_ff <= 16'h0;
            brk_ms_ff <= brk_ms_ff - 8'h1;
            if (brk_ms_ff == 8'h1)
               brk_ff <= 1'b0;
         end else
            ms_cnt_ff <= ms_cnt_ff + 16'h1;
      end
   end

   // tx fifo
   always @(posedge sys_clk) begin
      if (byte_data && !tx_full)
         tx_mem[tx_wp_ff] <= rpt_byte;
   end
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_wp_ff <= {AW{1'b0}};
         tx_rp_ff <= {AW{1'b0}};
         tx_cnt_ff <= 16'h0;
      end else if (flush_tx) begin
         tx_rp_ff <= tx_wp_ff;
         tx_cnt_ff <= 16'h0;
      end else begin
         if (byte_data && !tx_full)
            tx_wp_ff <= hrub_inc(tx_wp_ff);
         if (tx_take)
            tx_rp_ff <= hrub_inc(tx_rp_ff);
         tx_cnt_ff <= tx_cnt_ff + {15'h0, byte_data && !tx_full} - {15'h0, tx_take};
      end
   end

   // transmitter
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st_ff <= TX_IDLE;
         uart_tx_ff <= 1'b1;
         tx_sh_ff <= 8'h0;
         tx_n_ff <= 4'h0;
         tx_p_ff <= 1'b0;
         tx_acc_ff <= 32'h0;
         tx_half_ff <= 3'h0;
      end else begin
         tx_acc_ff <= tick2 ? tx_acc_ff + baud2 - `HRUB_CLK_HZ : tx_acc_ff + baud2;
         if (brk_ff) begin
            uart_tx_ff <= 1'b0;
            tx_st_ff <= TX_IDLE;
         end else if (tx_st_ff == TX_IDLE) begin
            uart_tx_ff <= 1'b1;
            if (tx_take) begin
               tx_sh_ff <= tx_mem[tx_rp_ff];
               tx_p_ff <= hrub_par(cfg_parity_ff, tx_mem[tx_rp_ff], cfg_bits_ff);
               uart_tx_ff <= 1'b0;
               tx_st_ff <= TX_START;
               tx_half_ff <= 3'h1;
               tx_n_ff <= 4'h0;
            end
         end else if (tick2) begin
            tx_half_ff <= tx_half_ff - 3'h1;
            if (tx_half_ff == 3'h0) begin
               case (tx_st_ff)
                  TX_START, TX_DATA: begin
                     if (tx_n_ff == cfg_bits_ff) begin
                        if (cfg_parity_ff == `HRUB_PAR_NONE) begin
                           uart_tx_ff <= 1'b1;
                           tx_st_ff <= TX_STOP;
                           tx_half_ff <= !cfg_stop_ff ? 3'h1 : (cfg_bits_ff == 4'h5 ? 3'h2 : 3'h3);
                        end else begin
                           uart_tx_ff <= tx_p_ff;
                           tx_st_ff <= TX_PAR;
                           tx_half_ff <= 3'h1;
                        end
                     end else begin
                        uart_tx_ff <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                        tx_n_ff <= tx_n_ff + 4'h1;
                        tx_st_ff <= TX_DATA;
                        tx_half_ff <= 3'h1;
                     end
                  end
                  TX_PAR: begin
                     uart_tx_ff <= 1'b1;
                     tx_st_ff <= TX_STOP;
                     tx_half_ff <= !cfg_stop_ff ? 3'h1 : (cfg_bits_ff == 4'h5 ? 3'h2 : 3'h3);
                  end
                  default: tx_st_ff <= TX_IDLE;
               endcase
            end
         end
      end
   end

   // receiver, centre sampled
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         cts_s1_ff <= 1'b1;
         cts_s2_ff <= 1'b1;
         rx_acc_ff <= 32'h0;
         rx_st_ff <= 3'h0;
         rx_n_ff <= 4'h0;
         rx_sh_ff <= 8'h0;
         rx_bit_ff <= 4'h0;
         rx_pbit_ff <= 1'b0;
      end else begin
         rx_s1_ff <= uart_rx;
         rx_s2_ff <= rx_s1_ff;
         cts_s1_ff <= uart_cts_n;
         cts_s2_ff <= cts_s1_ff;
         rx_acc_ff <= tick16 ? rx_acc_ff + baud16 - `HRUB_CLK_HZ : rx_acc_ff + baud16;
         if (tick16) begin
            rx_n_ff <= rx_n_ff + 4'h1;
            case (rx_st_ff)
               3'h0: if (!rx_s2_ff) begin
                  rx_st_ff <= 3'h1;
                  rx_n_ff <= 4'h0;
               end
               3'h1: if (rx_n_ff == 4'h7) begin
                  rx_st_ff <= rx_s2_ff ? 3'h0 : 3'h2;
                  rx_n_ff <= 4'h0;
                  rx_bit_ff <= 4'h0;
               end
               3'h2: if (rx_n_ff == 4'hf) begin
                  rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
                  rx_bit_ff <= rx_bit_ff + 4'h1;
                  if (rx_bit_ff == cfg_bits_ff - 4'h1)
                     rx_st_ff <= (cfg_parity_ff == `HRUB_PAR_NONE) ? 3'h4 : 3'h3;
               end
               3'h3: if (rx_n_ff == 4'hf) begin
                  rx_pbit_ff <= rx_s2_ff;
                  rx_st_ff <= 3'h4;
               end
               default: if (rx_n_ff == 4'hf)
                  rx_st_ff <= 3'h0;
            endcase
         end
      end
   end

   // rx fifo and parity
   wire [7:0] rx_word = rx_sh_ff >> (4'h8 - cfg_bits_ff);
   wire       rx_push = rx_done && !rx_full && rx_s2_ff;
   always @(posedge sys_clk) begin
      if (rx_push)
         rx_mem[rx_wp_ff] <= rx_word;
   end
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_wp_ff <= {AW{1'b0}};
         rx_rp_ff <= {AW{1'b0}};
         rx_cnt_ff <= 16'h0;
         rx_data_ff <= 8'h0;
         perr_ff <= 1'b0;
      end else begin
         if (rx_done && cfg_parity_ff != `HRUB_PAR_NONE &&
             rx_pbit_ff != hrub_par(cfg_parity_ff, rx_word, cfg_bits_ff))
            perr_ff <= 1'b1;
         if (flush_rx) begin
            rx_rp_ff <= rx_wp_ff;
            rx_cnt_ff <= 16'h0;
         end else begin
            if (rx_push)
               rx_wp_ff <= hrub_inc(rx_wp_ff);
            if (rx_pop && rx_avail) begin
               rx_data_ff <= rx_mem[rx_rp_ff];
               rx_rp_ff <= hrub_inc(rx_rp_ff);
            end
            rx_cnt_ff <= rx_cnt_ff + {15'h0, rx_push} - {15'h0, rx_pop && rx_avail};
         end
      end
   end
endmodule

// ==== rtl/hrub_map.vh ====
// hrub_map.vh: report ids, field codes, defaults and timing
// assumes inclusion by the bridge module and the bench
`ifndef HRUB_MAP_VH
`define HRUB_MAP_VH
`define HRUB_ID_DATA_MIN   8'h01
`define HRUB_ID_DATA_MAX   8'h3f
`define HRUB_ID_CONFIG     8'h50
`define HRUB_ID_BRK_SET    8'h51
`define HRUB_ID_BRK_STOP   8'h52
`define HRUB_PAR_NONE      3'h0
`define HRUB_PAR_EVEN      3'h1
`define HRUB_PAR_ODD       3'h2
`define HRUB_PAR_MARK      3'h3
`define HRUB_PAR_SPACE     3'h4
`define HRUB_FLUSH_TX_OPEN  0
`define HRUB_FLUSH_TX_CLOSE 1
`define HRUB_FLUSH_RX_OPEN  2
`define HRUB_FLUSH_RX_CLOSE 3
`define HRUB_BAUD_MIN      32'd300
`define HRUB_BAUD_MAX      32'd500000
`define HRUB_BAUD_DEF      32'd9600
`define HRUB_BITS_DEF      4'h8
`define HRUB_BRK_MAX_MS    8'h7d
`define HRUB_CLK_HZ        32'd20000000
`define HRUB_MS_CYC        (`HRUB_CLK_HZ / 32'd1000)
`define HRUB_FIFO_DEPTH    480
`endif

// ==== sim/hrub_bridge_properties.sv ====
// hrub_bridge_properties.sv: port assertions for the bridge
// assumes a bind onto hrub_bridge, one sys_clk domain
`timescale 1ns/10ps
module hrub_bridge_chk #(
   parameter DEPTH = 480
) (
   // clock and reset
   input wire        sys_clk,
   input wire        sys_rst,
   // report side
   input wire        rpt_valid,
   input wire        rpt_first,
   input wire [7:0]  rpt_byte,
   input wire        rx_pop,
   input wire        rx_avail,
   input wire [7:0]  in_report_id,
   // status and pins
   input wire [15:0] tx_count,
   input wire [15:0] rx_count,
   input wire        break_active,
   input wire [31:0] cfg_baud_ff,
   input wire [2:0]  cfg_parity_ff,
   input wire        cfg_flow_ff,
   input wire [3:0]  cfg_bits_ff,
   input wire        cfg_stop_ff,
   input wire        uart_tx_ff,
   input wire        uart_rts_n
);
   // inside a data report
   reg in_data_ff;
   always @(posedge sys_clk or posedge sys_rst)
      if (sys_rst)
         in_data_ff <= 1'b0;
      else if (rpt_valid && rpt_first)
         in_data_ff <= (rpt_byte >= 8'h01) && (rpt_byte <= 8'h3f);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   tx_grow_a: assert property (tx_count > $past(tx_count) |-> $past(rpt_valid && !rpt_first && in_data_ff))
      else $error("tx count rose without a payload byte");
   depth_cap_a: assert property (tx_count <= DEPTH && rx_count <= DEPTH)
      else $error("fifo count above depth");
   report_id_a: assert property (in_report_id == ((rx_count > 16'd63) ? 8'h3f : rx_count[7:0]))
      else $error("in report id wrong");
   rx_avail_a: assert property (rx_avail == (rx_count != 16'h0000))
      else $error("rx avail wrong");
   brk_flush_a: assert property ($rose(break_active) |-> tx_count == 16'h0000)
      else $error("tx fifo not empty at break start");
   brk_low_a: assert property (break_active && $past(break_active) |-> !uart_tx_ff)
      else $error("tx line high during break");
   brk_end_a: assert property ($fell(break_active) |-> ##[0:2] uart_tx_ff)
      else $error("tx not idle after break");
   cfg_cause_a: assert property (!$stable({cfg_baud_ff, cfg_parity_ff, cfg_flow_ff, cfg_bits_ff, cfg_stop_ff})
      |-> $past(rpt_valid) || $past(rpt_valid, 2))
      else $error("config changed without a report");
   cfg_legal_a: assert property (cfg_baud_ff >= 32'd300 && cfg_baud_ff <= 32'd500000 && cfg_parity_ff <= 3'h4
      && cfg_bits_ff >= 4'h5 && cfg_bits_ff <= 4'h8)
      else $error("config holds an illegal value");
   rts_free_a: assert property (!cfg_flow_ff |-> !uart_rts_n)
      else $error("rts high without flow");
   cover property ($rose(break_active));
   cover property (rx_pop && rx_avail);
   cover property (cfg_flow_ff && tx_count != 16'h0000);
endmodule
bind hrub_bridge hrub_bridge_chk #(.DEPTH(DEPTH)) u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .rpt_valid(rpt_valid), .rpt_first(rpt_first),
   .rpt_byte(rpt_byte), .rx_pop(rx_pop), .rx_avail(rx_avail), .in_report_id(in_report_id),
   .tx_count(tx_count), .rx_count(rx_count), .break_active(break_active), .cfg_baud_ff(cfg_baud_ff),
   .cfg_parity_ff(cfg_parity_ff), .cfg_flow_ff(cfg_flow_ff), .cfg_bits_ff(cfg_bits_ff),
   .cfg_stop_ff(cfg_stop_ff), .uart_tx_ff(uart_tx_ff), .uart_rts_n(uart_rts_n)
);

// ==== sim/hrub_uart_peer.sv ====
// hrub_uart_peer.sv: serial device model
// assumes the bench sets nb, pm and cts_n; bc (cycles a bit) keeps its default of 40
`timescale 1ns/10ps
module hrub_uart_peer (
   // clock and serial lines
   input  wire sys_clk,
   input  wire tx,
   output reg  rx,
   output reg  cts_n
);
   integer   bc = 40;
   integer   nb = 8;
   integer   pm = 0;
   reg [8:0] got[$];
   realtime  st[$];
   integer   i;
   realtime  t;
   reg       ok;
   reg [8:0] d;
   function automatic pbit(input [7:0] v, input integer n, input integer m);
      reg o;
      begin
         o = ^(v & ((8'h01 << n) - 8'h01));
         pbit = (m == 1) ? o : (m == 2) ? !o : (m == 3);
      end
   endfunction
   task send(input [7:0] v);
      integer j;
      begin
         rx = 1'b0;
         repeat (bc) @(negedge sys_clk);
         for (j = 0; j < nb; j = j + 1) begin
            rx = v[j];
            repeat (bc) @(negedge sys_clk);
         end
         if (pm != 0) begin
            rx = pbit(v, nb, pm);
            repeat (bc) @(negedge sys_clk);
         end
         rx = 1'b1;
         repeat (bc) @(negedge sys_clk);
      end
   endtask
   // decoder, bad stop drops frame
   initial begin
      rx = 1'b1;
      cts_n = 1'b0;
      forever begin
         @(negedge tx);
         t = $realtime;
         repeat (bc / 2) @(negedge sys_clk);
         ok = !tx;
         d = 9'h000;
         for (i = 0; i < nb; i = i + 1) begin
            repeat (bc) @(negedge sys_clk);
            d[i] = tx;
         end
         if (pm != 0) begin
            repeat (bc) @(negedge sys_clk);
            d[8] = tx;
         end
         repeat (bc) @(negedge sys_clk);
         if (ok && tx) begin
            got.push_back(d);
            st.push_back(t);
         end
         else
            wait (tx === 1'b1);
      end
   end
endmodule

// ==== sim/tb.sv ====
// tb.sv: self-checking bench for the hid report uart bridge
// assumes hrub_uart_peer on the serial pins and a short millisecond count
`timescale 1ns/10ps
`include "hrub_map.vh"
module tb;
   localparam MS = 20;
   reg         sys_clk, sys_rst, rpt_valid, rpt_first, rx_pop, policy_wr, uart_enable;
   reg  [7:0]  rpt_byte, policy_val, b;
   wire        rx_avail, break_active, cfg_flow_ff, cfg_stop_ff, parity_err, uart_tx_ff, uart_rx;
   wire        uart_rts_n, uart_cts_n;
   wire [7:0]  rx_data_ff, in_report_id;
   wire [15:0] tx_count, rx_count;
   wire [31:0] cfg_baud_ff;
   wire [2:0]  cfg_parity_ff;
   wire [3:0]  cfg_bits_ff;
   integer     num_errors = 0;
   integer     compares = 0;
   integer     k, e, g;
   reg  [8:0]  exp_tx[$];
   reg  [7:0]  exp_rx[$];
   hrub_bridge #(.DEPTH(480), .MS_CYC(MS)) DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .rpt_valid(rpt_valid), .rpt_first(rpt_first),
      .rpt_byte(rpt_byte), .rx_pop(rx_pop), .rx_avail(rx_avail), .rx_data_ff(rx_data_ff),
      .in_report_id(in_report_id), .policy_wr(policy_wr), .policy_val(policy_val),
      .uart_enable(uart_enable), .tx_count(tx_count), .rx_count(rx_count), .break_active(break_active),
      .cfg_baud_ff(cfg_baud_ff), .cfg_parity_ff(cfg_parity_ff), .cfg_flow_ff(cfg_flow_ff),
      .cfg_bits_ff(cfg_bits_ff), .cfg_stop_ff(cfg_stop_ff), .parity_err(parity_err),
      .uart_tx_ff(uart_tx_ff), .uart_rx(uart_rx), .uart_rts_n(uart_rts_n), .uart_cts_n(uart_cts_n));
   hrub_uart_peer peer (.sys_clk(sys_clk), .tx(uart_tx_ff), .rx(uart_rx), .cts_n(uart_cts_n));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("compares=%0d errors=%0d", compares, num_errors);
         if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task lim(input integer n);
      if (e >= n) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   endtask
   task rpt(input [7:0] v, input f);
      begin
         @(negedge sys_clk);
         rpt_valid = 1'b1;
         rpt_first = f;
         rpt_byte = v;
         @(negedge sys_clk);
         rpt_valid = 1'b0;
      end
   endtask
   task cfg(input [31:0] bd, input [7:0] p, input [7:0] fl, input [7:0] nb, input [7:0] sb);
      begin
         rpt(`HRUB_ID_CONFIG, 1'b1);
         for (g = 0; g < 4; g = g + 1)
            rpt(bd[8*g +: 8], 1'b0);
         rpt(p, 1'b0);
         rpt(fl, 1'b0);
         rpt(nb, 1'b0);
         rpt(sb, 1'b0);
         @(negedge sys_clk);
      end
   endtask
   task data(input integer n);
      begin
         rpt(n[7:0], 1'b1);
         for (g = 0; g < n; g = g + 1) begin
            b = $urandom;
            exp_tx.push_back({peer.pbit(b, peer.nb, peer.pm), b & ((8'h01 << peer.nb) - 8'h01)});
            rpt(b, 1'b0);
         end
      end
   endtask
   task wait_tx;
      begin
         for (e = 0; peer.got.size() < exp_tx.size() && e < 20000; e = e + 1)
            @(negedge sys_clk);
         lim(20000);
         while (exp_tx.size() > 0)
            chk(peer.got.pop_front(), exp_tx.pop_front());
      end
   endtask
   task rst_chk;
      begin
         chk(cfg_baud_ff, `HRUB_BAUD_DEF);
         chk({cfg_parity_ff, cfg_flow_ff, cfg_bits_ff, cfg_stop_ff}, 9'h010);
         chk({uart_tx_ff, break_active, tx_count}, 18'h20000);
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {sys_rst, rpt_valid, rpt_first, rx_pop, policy_wr, uart_enable} = 6'h20;
      {rpt_byte, policy_val} = 16'h0000;
      void'($urandom(32'hee194bd9));
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      rst_chk;
      policy_val = 8'h05;
      policy_wr = 1'b1;
      @(negedge sys_clk);
      policy_wr = 1'b0;
      uart_enable = 1'b1;
      $display("test reset done");
      for (k = 0; k < 5; k = k + 1) begin
         peer.pm = k;
         peer.nb = 5 + k % 4;
         cfg(32'd500000, k[7:0], 8'h00, peer.nb[7:0], {7'h00, ~k[0]});
         chk(cfg_baud_ff, 32'd500000);
         chk({cfg_parity_ff, cfg_bits_ff, cfg_stop_ff}, {k[2:0], peer.nb[3:0], ~k[0]});
         data(2);
         wait_tx;
         g = (peer.st[1] - peer.st[0]) / 50.0;
         e = (1 + peer.nb + (k != 0)) * 40 + (k[0] ? 40 : (peer.nb == 5 ? 60 : 80));
         chk(g >= e - 2 && g <= e + 40, 1);
         peer.st.delete();
      end
      cfg(32'd299, 8'h00, 8'h00, 8'h08, 8'h00);
      cfg(32'd500000, 8'h05, 8'h00, 8'h08, 8'h00);
      cfg(32'd500000, 8'h00, 8'h00, 8'h04, 8'h00);
      chk({cfg_baud_ff[19:0], cfg_parity_ff, cfg_bits_ff, cfg_stop_ff}, {20'd500000, 3'h4, 4'h5, 1'b1});
      cfg(32'd500000, 8'h00, 8'h00, 8'h08, 8'h00);
      {peer.nb, peer.pm} = {32'd8, 32'd0};
      $display("test frames done");
      for (k = 0; k < 3; k = k + 1) begin
         b = $urandom;
         exp_rx.push_back(b);
         peer.send(b);
      end
      for (e = 0; rx_count !== 16'd3 && e < 200; e = e + 1)
         @(negedge sys_clk);
      lim(200);
      chk({in_report_id, rx_avail}, {8'h03, 1'b1});
      while (exp_rx.size() > 0) begin
         rx_pop = 1'b1;
         @(negedge sys_clk);
         rx_pop = 1'b0;
         chk(rx_data_ff, exp_rx.pop_front());
         @(negedge sys_clk);
      end
      chk({rx_count, rx_avail}, 17'h00000);
      $display("test receive done");
      data(10);
      repeat (300) @(negedge sys_clk);
      rpt(`HRUB_ID_BRK_SET, 1'b1);
      rpt(8'h05, 1'b0);
      @(negedge sys_clk);
      chk({break_active, tx_count}, 17'h10000);
      for (e = 0; break_active === 1'b1 && e < 3000; e = e + 1)
         @(negedge sys_clk);
      chk(e >= 5 * MS - 4 && e <= 5 * MS + 2, 1);
      repeat (800) @(negedge sys_clk);
      chk({peer.got.size(), uart_tx_ff}, {32'd0, 1'b1});
      exp_tx.delete();
      rpt(`HRUB_ID_BRK_SET, 1'b1);
      rpt(8'h7e, 1'b0);
      rpt(`HRUB_ID_BRK_STOP, 1'b1);
      chk({break_active, uart_tx_ff}, 2'b01);
      rpt(`HRUB_ID_BRK_SET, 1'b1);
      rpt(8'h00, 1'b0);
      repeat (300) @(negedge sys_clk);
      chk({break_active, uart_tx_ff}, 2'b10);
      rpt(`HRUB_ID_BRK_STOP, 1'b1);
      repeat (3) @(negedge sys_clk);
      chk({break_active, uart_tx_ff}, 2'b01);
      $display("test break done");
      peer.cts_n = 1'b1;
      cfg(32'd500000, 8'h00, 8'h01, 8'h08, 8'h00);
      data(4);
      repeat (200) @(negedge sys_clk);
      chk({tx_count, uart_tx_ff}, {16'd4, 1'b1});
      peer.send(8'h3c);
      peer.send(8'hc3);
      repeat (10) @(negedge sys_clk);
      policy_val = 8'h0a;
      policy_wr = 1'b1;
      @(negedge sys_clk);
      policy_wr = 1'b0;
      uart_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({tx_count, rx_count}, {16'd4, 16'd2});
      uart_enable = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({tx_count, rx_count}, 32'h0);
      exp_tx.delete();
      peer.got.delete();
      peer.cts_n = 1'b0;
      data(2);
      wait_tx;
      $display("test flow done");
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      rst_chk;
      $display("test rereset done");
      give_verdict;
   end
endmodule
